// ===== dgp_pins.sv
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// far side of both ports: the outside world drives a pin only while the
// port leaves it as an input, otherwise the wire follows the port's drive
module dgp_pins (
  input wire logic [7:0] a_drv_in,
  input wire logic [7:0] a_oe_n_in,
  input wire logic [7:0] a_ext_in,
  input wire logic [7:0] b_drv_in,
  input wire logic [7:0] b_oe_n_in,
  input wire logic [7:0] b_ext_in,
  output logic [7:0] a_level_out,
  output logic [7:0] b_level_out
);
  // wire level of port a, port drive wins when enabled
  assign a_level_out = (a_oe_n_in & a_ext_in) | (~a_oe_n_in & a_drv_in);
  // wire level of port b, pulse outputs arrive through the port drive
  assign b_level_out = (b_oe_n_in & b_ext_in) | (~b_oe_n_in & b_drv_in);
endmodule
`default_nettype wire

// ===== dgp_pkg.sv
////////////////////////////////////////////////////////////////////////////////
// shared constants of the dual gpio port
package dgp_pkg;

  // port width and filtered input layout on port a
  localparam int unsigned PORT_W = 8;
  localparam int unsigned CAP_W = 4;
  localparam int unsigned EDGE_W = 5;
  localparam int unsigned FILT_W = 6;
  localparam int unsigned TIMER_BIT = 4;
  localparam int unsigned TRIG_BIT = 5;

  // register byte addresses on apb
  localparam logic [31:0] ADDR_PORT_A_DATA = 32'hfffff01c;
  localparam logic [31:0] ADDR_PORT_A_DIR = 32'h0ffff03c;
  localparam logic [31:0] ADDR_PORT_B_DATA = 32'hfffff020;
  localparam logic [31:0] ADDR_PORT_B_DIR = 32'h0ffff040;
  localparam logic [31:0] ADDR_RISE_EN = 32'hfffff0cc;
  localparam logic [31:0] ADDR_FALL_EN = 32'hfffff0d0;

  // reset values
  localparam logic [7:0] DIR_RESET = 8'hff;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] EDGE_RESET = 8'h00;
  // only bits 4..0 of the edge enables exist
  localparam logic [7:0] EDGE_MASK = 8'h1f;

  // noise filter: least stable time before a level is accepted
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned FILTER_TIME_NS = 120;
  localparam int unsigned FILTER_CYCLES =
    (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // register selected by the address decoder
  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_A_DATA = 3'b001,
    SEL_A_DIR = 3'b010,
    SEL_B_DATA = 3'b011,
    SEL_B_DIR = 3'b100,
    SEL_RISE = 3'b101,
    SEL_FALL = 3'b110
  } dgp_sel_t;

endpackage

// ===== dgp_port.sv
// How it works
// - port a has eight pins, direction per bit
// - output pins of port a drive latch value
// - port a reads pin when input, else latch
// - reset sets port a direction to all ones
// - pin shows latch ORed with alternate output
// - capture, timer, trigger inputs are noise filtered
// - rise and fall enables jointly select valid edge
// - rise enable bits 0-3 capture, 4 timer
// - rise enable resets zero, upper bits read zero
// - port a direction register fully read/write
// - port b: eight pins, same direction scheme
// - port b data read gives pin or latch
// - port b pins carry the eight pulse outputs
// - reset sets port b to input mode
// - port b output pins read back latch
// - data write updates latch, drives if output
// - fall enable bit 1 raises request on fall
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none

module dgp_port #(
  parameter int unsigned FILTER_LEN = dgp_pkg::FILTER_CYCLES
) (
  input wire logic clk_in,
  input wire logic reset_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // port a pins
  input wire logic [7:0] port_a_pin_in,
  output logic [7:0] port_a_pin_out,
  output logic [7:0] port_a_oe_n_out,
  input wire logic [7:0] port_a_alt_in,
  // port b pins
  input wire logic [7:0] port_b_pin_in,
  output logic [7:0] port_b_pin_out,
  output logic [7:0] port_b_oe_n_out,
  input wire logic [7:0] pulse_output_in,
  // filtered alternate inputs of port a
  output logic [3:0] capture_input_out,
  output logic timer_count_input_out,
  output logic pulse_output_trigger_input_out,
  // edge requests, one-cycle pulses
  output logic [3:0] capture_irq_out,
  output logic timer_input_interrupt_out
);

  localparam int unsigned CNT_W = $clog2(FILTER_LEN + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(FILTER_LEN - 1);

  // refuse a filter length the counter cannot serve
  if (FILTER_LEN < 1 || FILTER_LEN > 255)
  begin : g_bad_len
    $error("filter length out of range");
  end
  //////////////////////////////////////////////////////////////////////////////
  // address decoding
  function automatic dgp_pkg::dgp_sel_t sel_of(input logic [31:0] addr);
    dgp_pkg::dgp_sel_t s;
    s = dgp_pkg::SEL_NONE;
    case (addr)
      dgp_pkg::ADDR_PORT_A_DATA: s = dgp_pkg::SEL_A_DATA;
      dgp_pkg::ADDR_PORT_A_DIR: s = dgp_pkg::SEL_A_DIR;
      dgp_pkg::ADDR_PORT_B_DATA: s = dgp_pkg::SEL_B_DATA;
      dgp_pkg::ADDR_PORT_B_DIR: s = dgp_pkg::SEL_B_DIR;
      dgp_pkg::ADDR_RISE_EN: s = dgp_pkg::SEL_RISE;
      dgp_pkg::ADDR_FALL_EN: s = dgp_pkg::SEL_FALL;
      default: s = dgp_pkg::SEL_NONE;
    endcase
    return s;
  endfunction
  // registers
  logic [7:0] a_latch_r; // port a output latch
  logic [7:0] a_dir_r; // port a direction, 1 = input
  logic [7:0] b_latch_r; // port b output latch
  logic [7:0] b_dir_r; // port b direction, 1 = input
  logic [7:0] rise_en_r; // rising edge enables
  logic [7:0] fall_en_r; // falling edge enables
  logic pready_r; // access phase answer
  logic [31:0] prdata_r; // read data
  logic pslverr_r; // unmapped address answer
  // pin synchronisers
  logic [7:0] a_meta_r;
  logic [7:0] a_sync_r;
  logic [7:0] b_meta_r;
  logic [7:0] b_sync_r;
  // filter state
  logic [dgp_pkg::FILT_W-1:0] filt_r;
  logic [dgp_pkg::FILT_W-1:0] filt_d_r;
  logic [CNT_W-1:0] cnt_r [dgp_pkg::FILT_W];
  // pin drivers and edge requests
  logic [7:0] a_pin_r;
  logic [7:0] b_pin_r;
  logic [dgp_pkg::EDGE_W-1:0] irq_r;
  //////////////////////////////////////////////////////////////////////////////
  // bus decode
  dgp_pkg::dgp_sel_t sel;
  wire access = psel_in & penable_in;
  wire done = access & pready_r; // edge at which the transfer ends
  wire wr_en = done & pwrite_in & pstrb_in[0];
  wire mapped = (sel != dgp_pkg::SEL_NONE);
  assign sel = sel_of(paddr_in);
  // read views: pin level when input, latch when output
  wire [7:0] a_view = (a_dir_r & a_sync_r) | (~a_dir_r & a_latch_r);
  wire [7:0] b_view = (b_dir_r & b_sync_r) | (~b_dir_r & b_latch_r);
  // read mux
  logic [7:0] rd_byte;
  always_comb
  begin
    case (sel)
      dgp_pkg::SEL_A_DATA: rd_byte = a_view;
      dgp_pkg::SEL_A_DIR: rd_byte = a_dir_r;
      dgp_pkg::SEL_B_DATA: rd_byte = b_view;
      dgp_pkg::SEL_B_DIR: rd_byte = b_dir_r;
      dgp_pkg::SEL_RISE: rd_byte = rise_en_r;
      dgp_pkg::SEL_FALL: rd_byte = fall_en_r;
      default: rd_byte = 8'h00;
    endcase
  end

  // write strobes per register
  wire wr_a_data = wr_en & (sel == dgp_pkg::SEL_A_DATA);
  wire wr_a_dir = wr_en & (sel == dgp_pkg::SEL_A_DIR);
  wire wr_b_data = wr_en & (sel == dgp_pkg::SEL_B_DATA);
  wire wr_b_dir = wr_en & (sel == dgp_pkg::SEL_B_DIR);
  wire wr_rise = wr_en & (sel == dgp_pkg::SEL_RISE);
  wire wr_fall = wr_en & (sel == dgp_pkg::SEL_FALL);
  wire [7:0] wbyte = pwdata_in[7:0];
  //////////////////////////////////////////////////////////////////////////////
  // apb answer: one wait state, then pready with data
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r <= access & ~pready_r;
      prdata_r <= {24'h00_0000, rd_byte};
      pslverr_r <= access & ~pready_r & ~mapped;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // port a registers
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      a_latch_r <= dgp_pkg::LATCH_RESET;
      a_dir_r <= dgp_pkg::DIR_RESET;
    end
    else
    begin
      if (wr_a_data)
        a_latch_r <= wbyte;
      if (wr_a_dir)
        a_dir_r <= wbyte;
    end
  end
  // port b registers
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      b_latch_r <= dgp_pkg::LATCH_RESET;
      b_dir_r <= dgp_pkg::DIR_RESET;
    end
    else
    begin
      if (wr_b_data)
        b_latch_r <= wbyte;
      if (wr_b_dir)
        b_dir_r <= wbyte;
    end
  end
  // edge enables, upper bits held at zero
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      rise_en_r <= dgp_pkg::EDGE_RESET;
      fall_en_r <= dgp_pkg::EDGE_RESET;
    end
    else
    begin
      if (wr_rise)
        rise_en_r <= wbyte & dgp_pkg::EDGE_MASK;
      if (wr_fall)
        fall_en_r <= wbyte & dgp_pkg::EDGE_MASK;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // pin drivers: latch ORed with alternate output, registered
  wire [7:0] a_pin_nxt = a_latch_r | port_a_alt_in;
  wire [7:0] b_pin_nxt = b_latch_r | pulse_output_in;
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      a_pin_r <= dgp_pkg::LATCH_RESET;
      b_pin_r <= dgp_pkg::LATCH_RESET;
    end
    else
    begin
      a_pin_r <= a_pin_nxt;
      b_pin_r <= b_pin_nxt;
    end
  end
  // two-flop synchronisers for all pins
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      a_meta_r <= 8'h00;
      a_sync_r <= 8'h00;
      b_meta_r <= 8'h00;
      b_sync_r <= 8'h00;
    end
    else
    begin
      a_meta_r <= port_a_pin_in;
      a_sync_r <= a_meta_r;
      b_meta_r <= port_b_pin_in;
      b_sync_r <= b_meta_r;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // noise filter: a new level must hold for FILTER_LEN samples
  for (genvar i = 0; i < dgp_pkg::FILT_W; i++)
  begin : g_filt
    wire differs = (a_sync_r[i] != filt_r[i]);
    wire settle = differs & (cnt_r[i] == CNT_LAST);
    always_ff @(posedge clk_in)
    begin
      if (reset_in)
      begin
        cnt_r[i] <= '0;
        filt_r[i] <= 1'b0;
      end
      else if (!differs)
        cnt_r[i] <= '0; // glitch shorter than filter is dropped
      else if (settle)
      begin
        cnt_r[i] <= '0;
        filt_r[i] <= a_sync_r[i];
      end
      else
        cnt_r[i] <= cnt_r[i] + 1'b1;
    end
  end
  // previous filtered level for edge detection
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      filt_d_r <= '0;
    else
      filt_d_r <= filt_r;
  end
  //////////////////////////////////////////////////////////////////////////////
  // edge requests gated by rise and fall enables
  wire [dgp_pkg::EDGE_W-1:0] f_now = filt_r[dgp_pkg::EDGE_W-1:0];
  wire [dgp_pkg::EDGE_W-1:0] f_old = filt_d_r[dgp_pkg::EDGE_W-1:0];
  wire [dgp_pkg::EDGE_W-1:0] rise = f_now & ~f_old;
  wire [dgp_pkg::EDGE_W-1:0] fall = ~f_now & f_old;
  wire [dgp_pkg::EDGE_W-1:0] irq_nxt =
    (rise & rise_en_r[dgp_pkg::EDGE_W-1:0]) |
    (fall & fall_en_r[dgp_pkg::EDGE_W-1:0]);
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      irq_r <= '0;
    else
      irq_r <= irq_nxt;
  end
  //////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flip-flops
  assign prdata_out = prdata_r;
  assign pready_out = pready_r;
  assign pslverr_out = pslverr_r;
  assign port_a_pin_out = a_pin_r;
  assign port_a_oe_n_out = a_dir_r; // low drives the pin
  assign port_b_pin_out = b_pin_r;
  assign port_b_oe_n_out = b_dir_r;
  assign capture_input_out = filt_r[dgp_pkg::CAP_W-1:0];
  assign timer_count_input_out = filt_r[dgp_pkg::TIMER_BIT];
  assign pulse_output_trigger_input_out = filt_r[dgp_pkg::TRIG_BIT];
  assign capture_irq_out = irq_r[dgp_pkg::CAP_W-1:0];
  assign timer_input_interrupt_out = irq_r[dgp_pkg::TIMER_BIT];
  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);
  // a finished write to the port a data register
  sequence s_wr_a_data;
    done && pwrite_in && pstrb_in[0] && sel == dgp_pkg::SEL_A_DATA;
  endsequence
  // an enabled filtered rise on capture input 0
  sequence s_rise0;
    rise[0] && rise_en_r[0];
  endsequence
  a_dir_after_reset: assert property (
    @(posedge clk_in) disable iff (1'b0)
    reset_in |=> port_a_oe_n_out == dgp_pkg::DIR_RESET &&
      port_b_oe_n_out == dgp_pkg::DIR_RESET)
    else $error("ports not in input mode after reset");
  a_pin_or_alt: assert property (
    1'b1 |=> port_a_pin_out == ($past(a_latch_r) | $past(port_a_alt_in)))
    else $error("port a pin is not latch or alternate");
  a_pulse_pin: assert property (
    1'b1 |=> port_b_pin_out == ($past(b_latch_r) | $past(pulse_output_in)))
    else $error("port b pin is not latch or pulse");
  a_read_a_view: assert property (
    access && !pready_r && !pwrite_in && sel == dgp_pkg::SEL_A_DATA
    |=> pready_out && prdata_out[7:0] ==
      (($past(a_dir_r) & $past(a_sync_r)) |
       (~$past(a_dir_r) & $past(a_latch_r))))
    else $error("port a read returned wrong view");
  a_read_b_latch: assert property (
    access && !pready_r && !pwrite_in && sel == dgp_pkg::SEL_B_DATA &&
      b_dir_r == 8'h00
    |=> prdata_out[7:0] == $past(b_latch_r))
    else $error("port b output read did not return latch");
  a_write_latch: assert property (
    s_wr_a_data |=> a_latch_r == $past(pwdata_in[7:0]) ##1
      port_a_pin_out == ($past(a_latch_r) | $past(port_a_alt_in)))
    else $error("port a data write not applied");
  a_edge_upper: assert property (
    rise_en_r[7:dgp_pkg::EDGE_W] == 3'b000 &&
      fall_en_r[7:dgp_pkg::EDGE_W] == 3'b000)
    else $error("edge enable upper bits not zero");
  a_rise_request: assert property (
    s_rise0 |=> capture_irq_out[0] ##1 !capture_irq_out[0])
    else $error("rising edge did not give one request");
  a_fall_request: assert property (
    fall[dgp_pkg::TIMER_BIT] && fall_en_r[dgp_pkg::TIMER_BIT]
    |=> timer_input_interrupt_out)
    else $error("falling edge request missing");
  a_no_enable: assert property (
    rise_en_r[1] == 1'b0 && fall_en_r[1] == 1'b0 |=> !capture_irq_out[1])
    else $error("request with both edge enables clear");
  a_filter_settle: assert property (
    $changed(filt_r[0]) |-> $past(cnt_r[0]) == CNT_LAST &&
      $past(a_sync_r[0]) == filt_r[0])
    else $error("filter changed before settling");
  a_unmapped_err: assert property (
    access && !pready_r && !mapped |=> pready_out && pslverr_out)
    else $error("unmapped access not flagged");
endmodule

`default_nettype wire

// ===== dual_gpio_port_edge_select_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dual_gpio_port_edge_select_tb;
  // clock, reset and apb master signals
  logic clk_in, reset_in, psel, penable, pwrite, pready, pslverr, err;
  logic [31:0] paddr, pwdata, prdata, rd, d;
  logic [3:0] pstrb, cap, cap_irq;
  // pin side: wire levels, drives, enables, outside values
  logic [7:0] a_pin, a_out, a_oe_n, a_alt, a_ext;
  logic [7:0] b_pin, b_out, b_oe_n, b_ext, pulse;
  logic tmr, trig, tmr_irq;
  // bookkeeping and the behavioural register model
  int miscompares, n_compared, seed, irq_cnt[6];
  int m_dir_a, m_lat_a, m_dir_b, m_lat_b, rise, fall;

  dgp_port #(.FILTER_LEN(1)) dgp_port_inst (.clk_in(clk_in),
    .reset_in(reset_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .port_a_pin_in(a_pin), .port_a_pin_out(a_out),
    .port_a_oe_n_out(a_oe_n), .port_a_alt_in(a_alt),
    .port_b_pin_in(b_pin), .port_b_pin_out(b_out),
    .port_b_oe_n_out(b_oe_n), .pulse_output_in(pulse),
    .capture_input_out(cap), .timer_count_input_out(tmr),
    .pulse_output_trigger_input_out(trig), .capture_irq_out(cap_irq),
    .timer_input_interrupt_out(tmr_irq));

  dgp_pins dgp_pins_inst (.a_drv_in(a_out), .a_oe_n_in(a_oe_n),
    .a_ext_in(a_ext), .b_drv_in(b_out), .b_oe_n_in(b_oe_n),
    .b_ext_in(b_ext), .a_level_out(a_pin), .b_level_out(b_pin));

  // free-running 25 mhz clock
  initial
  begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  // count request pulses per edge input, slot 5 stays zero
  always @(posedge clk_in)
  begin
    for (int i = 0; i < 4; i++) irq_cnt[i] += int'(cap_irq[i] === 1'b1);
    irq_cnt[4] += int'(tmr_irq === 1'b1);
  end

  //////////////////////////////////////////////////////////////////////////////
  // print the counts and the verdict, then stop
  task end_sim;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // compare a design value with its expectation
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // compare a counted number of request pulses
  task chk_cnt(input int got, input int exp);
    n_compared++;
    if (got != exp)
    begin
      miscompares++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer, held until pready is seen at an edge
  task apb(input logic w, input logic [31:0] a, input logic [31:0] wd,
    input logic [3:0] s);
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    pstrb <= s;
    @(posedge clk_in);
    penable <= 1'b1;
    for (int n = 0; n <= 20; n++)
    begin
      @(posedge clk_in);
      if (pready === 1'b1) break;
      // slave never answered
      if (n == 20)
      begin
        miscompares++;
        end_sim();
      end
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // full-byte write
  task wr(input logic [31:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd, 4'hf);
  endtask

  // read and compare data plus a clean response
  task rdc(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'hf);
    chk(rd, exp);
    chk(32'(err), 32'h0);
  endtask

  // expected data read: pin level for inputs, latch for outputs
  function automatic logic [31:0] exp_data(int dir, int lat, logic [7:0] e);
    return {24'h0, (dir[7:0] & e) | (~dir[7:0] & lat[7:0])};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    seed = 97085;
    {miscompares, n_compared} = 0;
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {a_ext, b_ext, a_alt, pulse} = '0;
    foreach (irq_cnt[i]) irq_cnt[i] = 0;
    reset_in = 1'b1;
    {m_dir_a, m_dir_b, m_lat_a, m_lat_b} = {32'hff, 32'hff, 64'h0};
    repeat (12) @(posedge clk_in);
    reset_in <= 1'b0;
    // reset values of the direction and edge enable registers
    rdc(dgp_pkg::ADDR_PORT_A_DIR, 32'hff);
    rdc(dgp_pkg::ADDR_PORT_B_DIR, 32'hff);
    rdc(dgp_pkg::ADDR_RISE_EN, 32'h0);
    rdc(dgp_pkg::ADDR_FALL_EN, 32'h0);
    // unmapped place gives an error and zero data
    apb(1'b0, 32'hfffff0d4, 32'h0, 4'hf);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
    // unused high enable bits stay zero
    wr(dgp_pkg::ADDR_RISE_EN, 32'hff);
    rdc(dgp_pkg::ADDR_RISE_EN, 32'h1f);
    // a write without the low byte strobe changes nothing
    apb(1'b1, dgp_pkg::ADDR_PORT_A_DIR, 32'h0, 4'he);
    rdc(dgp_pkg::ADDR_PORT_A_DIR, 32'hff);
    // random directions, latches, pins and alternate outputs
    repeat (40)
    begin
      d = $random(seed);
      wr(dgp_pkg::ADDR_PORT_A_DIR, d);
      m_dir_a = d[7:0];
      d = $random(seed);
      wr(dgp_pkg::ADDR_PORT_A_DATA, d);
      m_lat_a = d[7:0];
      d = $random(seed);
      wr(dgp_pkg::ADDR_PORT_B_DIR, d);
      m_dir_b = d[7:0];
      d = $random(seed);
      wr(dgp_pkg::ADDR_PORT_B_DATA, d);
      m_lat_b = d[7:0];
      d = $random(seed);
      {a_ext, b_ext, a_alt, pulse} <= d;
      repeat (6) @(posedge clk_in);
      rdc(dgp_pkg::ADDR_PORT_A_DIR, m_dir_a);
      rdc(dgp_pkg::ADDR_PORT_A_DATA, exp_data(m_dir_a, m_lat_a, a_ext));
      rdc(dgp_pkg::ADDR_PORT_B_DATA, exp_data(m_dir_b, m_lat_b, b_ext));
      chk(32'(a_oe_n), m_dir_a);
      chk(32'(a_out), m_lat_a | a_alt);
      chk(32'(b_oe_n), m_dir_b);
      chk(32'(b_out), m_lat_b | pulse);
    end
    // pulse outputs reach the pins once latch and direction are cleared
    wr(dgp_pkg::ADDR_PORT_B_DIR, 32'h0);
    // output pins read back the latch, not the pin level
    wr(dgp_pkg::ADDR_PORT_B_DATA, 32'h5a);
    rdc(dgp_pkg::ADDR_PORT_B_DATA, 32'h5a);
    wr(dgp_pkg::ADDR_PORT_B_DATA, 32'h0);
    pulse <= 8'($random(seed));
    repeat (3) @(posedge clk_in);
    chk(32'(b_out), 32'(pulse));
    // edge requests: every enable combination on every filtered input
    wr(dgp_pkg::ADDR_PORT_A_DIR, 32'hff);
    a_ext <= 8'h0;
    repeat (8) @(posedge clk_in);
    for (int k = 0; k < 4; k++)
      for (int i = 0; i < 6; i++)
      begin
        rise = k[0] ? (1 << i) & 32'h1f : 32'h1f ^ ((1 << i) & 32'h1f);
        fall = k[1] ? (1 << i) & 32'h1f : 32'h1f ^ ((1 << i) & 32'h1f);
        wr(dgp_pkg::ADDR_RISE_EN, rise);
        wr(dgp_pkg::ADDR_FALL_EN, fall);
        foreach (irq_cnt[j]) irq_cnt[j] = 0;
        a_ext[i] <= 1'b1;
        repeat (8) @(posedge clk_in);
        chk(32'({trig, tmr, cap}), 32'(1 << i));
        a_ext[i] <= 1'b0;
        repeat (8) @(posedge clk_in);
        for (int j = 0; j < 5; j++)
          chk_cnt(irq_cnt[j], (j == i) ? k[0] + k[1] : 0);
      end
    end_sim();
  end
endmodule
`default_nettype wire
